// File: include/spv_regs.svh
// register map, bit positions, reset values and mode codes for the
// sensor pad control and frame pulse block
// assumes: included by bare name from package and design modules
`ifndef SPV_REGS_SVH
`define SPV_REGS_SVH

`define SPV_ADDR_DRIVE 16'h3001
`define SPV_ADDR_DIR_A 16'h3002
`define SPV_ADDR_FS_DIR 16'h3004
`define SPV_ADDR_FORCE_A 16'h3006
`define SPV_ADDR_GP_FORCE 16'h3008
`define SPV_ADDR_PAD_LEVEL 16'h300A
`define SPV_ADDR_SEL_A 16'h3024
`define SPV_ADDR_GP_SEL 16'h3026
`define SPV_ADDR_GP_CHOICE 16'h3667
`define SPV_ADDR_LED_SEL 16'h3907
`define SPV_ADDR_MODE 16'h4310
`define SPV_ADDR_WIDTH_HI 16'h4311
`define SPV_ADDR_WIDTH_LO 16'h4312
`define SPV_ADDR_DELAY_B2 16'h4314
`define SPV_ADDR_DELAY_B1 16'h4315
`define SPV_ADDR_DELAY_B0 16'h4316

`define SPV_DRIVE_LSB 0
`define SPV_DRIVE_MSB 1
`define SPV_GP_DIR_BIT 0
`define SPV_ST_DIR_BIT 3
`define SPV_FS_DIR_BIT 7
`define SPV_FS_SEL_BIT 7
`define SPV_FS_VAL_BIT 7
`define SPV_ST_SEL_BIT 2
`define SPV_ST_VAL_BIT 2
`define SPV_LED_DIR_BIT 5
`define SPV_GP_SEL_BIT 4
`define SPV_GP_VAL_BIT 4
`define SPV_GP_CHOICE_BIT 4
`define SPV_LED_SEL_BIT 7
`define SPV_MODE_LSB 0
`define SPV_MODE_MSB 1

`define SPV_RST_BYTE 8'h00
`define SPV_RST_MODE 8'h01
`define SPV_MODE_OFF 2'h0
`define SPV_MODE_SOF 2'h1
`define SPV_MODE_EOF 2'h2
`define SPV_MODE_LONG 2'h3

`endif

// File: include/spv_pkg.sv
// types shared by the pad control top and the frame pulse generator
// assumes: spv_regs.svh is on the include path
`include "spv_regs.svh"
package spv_pkg;

    typedef logic [1:0] spv_mode_t;

    typedef enum logic [4:0] {
        SPV_IDLE  = 5'h01,
        SPV_DELAY = 5'h02,
        SPV_HIGH  = 5'h04,
        SPV_HOLD  = 5'h08,
        SPV_TAIL  = 5'h10
    } spv_state_e;

    typedef struct packed {
        spv_state_e state;
        logic [23:0] cnt;
        logic pulse;
    } spv_gen_s;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
    } spv_sync_s;

    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] dir_a;
        logic [7:0] fs_dir;
        logic [7:0] force_a;
        logic [7:0] gp_force;
        logic [7:0] sel_a;
        logic [7:0] gp_sel;
        logic [7:0] gp_choice;
        logic [7:0] led_sel;
        logic [7:0] mode;
        logic [7:0] width_hi;
        logic [7:0] width_lo;
        logic [7:0] delay_b2;
        logic [7:0] delay_b1;
        logic [7:0] delay_b0;
        logic [7:0] rdata;
        logic rvalid;
        logic [1:0] drive_code;
        logic fs_out;
        logic fs_oe_n;
        logic st_out;
        logic st_oe_n;
        logic led_out;
        logic led_oe_n;
        logic gp_out;
        logic gp_oe_n;
    } spv_top_s;

endpackage

// File: logic/spv_pad_sync.sv
// two-flop synchroniser for the pad input levels
// assumes: pad levels may change at any time relative to ref_clk
`timescale 1ns/100ps
module spv_pad_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] d,
    output logic [3:0] q
);
    import spv_pkg::*;

    spv_sync_s r;
    spv_sync_s next_r;

    // first stage feeds only the second stage
    always_comb begin
        next_r = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;

    property p_sync_two;
        @(posedge ref_clk) disable iff (reset)
        !reset [*3] |-> q == $past(d, 2);
    endproperty
    a_sync_two: assert property (p_sync_two)
        else $error("pad level not seen two cycles later");

endmodule

// File: logic/spv_frame_pulse.sv
// frame pulse generator: start, end or long mode, counted in clocks
// assumes: sof and eof are one-cycle pulses in ref_clk domain
`timescale 1ns/100ps
`include "spv_regs.svh"
module spv_frame_pulse (
    input wire logic ref_clk,
    input wire logic reset,
    input wire spv_pkg::spv_mode_t mode,
    input wire logic [23:0] delay,
    input wire logic [15:0] width,
    input wire logic sof,
    input wire logic eof,
    output logic pulse
);
    import spv_pkg::*;

    spv_gen_s r;
    spv_gen_s next_r;
    logic trig;
    logic [23:0] width_ext;

    always_comb begin
        next_r = r;
        width_ext = {8'h00, width};
        trig = ((mode == `SPV_MODE_SOF) && sof) ||
            ((mode == `SPV_MODE_EOF) && eof) ||
            ((mode == `SPV_MODE_LONG) && eof);
        case (r.state)
            SPV_IDLE: begin
                if (trig) begin
                    next_r.cnt = delay;
                    next_r.state = SPV_DELAY;
                end
            end
            SPV_DELAY: begin
                // one count is one clock
                if (r.cnt == 24'h00_0000) begin
                    next_r.pulse = 1'b1;
                    next_r.cnt = width_ext;
                    next_r.state = (mode == `SPV_MODE_LONG) ?
                        SPV_HOLD : SPV_HIGH;
                end else begin
                    next_r.cnt = r.cnt - 24'h00_0001;
                end
            end
            SPV_HIGH: begin
                if (r.cnt <= 24'h00_0001) begin
                    next_r.pulse = 1'b0;
                    next_r.state = SPV_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 24'h00_0001;
                end
            end
            SPV_HOLD: begin
                // long pulse stays up until the next frame start, then for width more clocks in the tail
                if (sof) begin
                    next_r.cnt = width_ext;
                    next_r.state = SPV_TAIL;
                end
            end
            SPV_TAIL: begin
                if (r.cnt <= 24'h00_0001) begin
                    next_r.pulse = 1'b0;
                    next_r.state = SPV_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 24'h00_0001;
                end
            end
            default: begin
                next_r.state = SPV_IDLE;
                next_r.pulse = 1'b0;
            end
        endcase
        // mode off aborts any pulse in flight
        if (mode == `SPV_MODE_OFF) begin
            next_r.state = SPV_IDLE;
            next_r.pulse = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r.state <= SPV_IDLE;
            r.cnt <= 24'h00_0000;
            r.pulse <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign pulse = r.pulse;

    property p_sof_trig;
        @(posedge ref_clk) disable iff (reset)
        (r.state == SPV_IDLE && mode == `SPV_MODE_SOF && sof) |=>
            (r.state == SPV_DELAY && r.cnt == $past(delay));
    endproperty
    a_sof_trig: assert property (p_sof_trig)
        else $error("start of frame did not arm the delay");

    property p_eof_only;
        @(posedge ref_clk) disable iff (reset)
        (r.state == SPV_IDLE && mode == `SPV_MODE_EOF && sof && !eof)
            |=> r.state == SPV_IDLE;
    endproperty
    a_eof_only: assert property (p_eof_only)
        else $error("end mode fired on start of frame");

    property p_rise;
        @(posedge ref_clk) disable iff (reset)
        (r.state == SPV_DELAY && r.cnt == 24'h00_0000 &&
            mode != `SPV_MODE_OFF) |=> pulse;
    endproperty
    a_rise: assert property (p_rise)
        else $error("pulse did not rise after delay");

    property p_step;
        @(posedge ref_clk) disable iff (reset)
        (r.state == SPV_DELAY && r.cnt != 24'h00_0000 &&
            mode != `SPV_MODE_OFF) |=>
            (r.cnt == $past(r.cnt) - 24'h00_0001 && !pulse);
    endproperty
    a_step: assert property (p_step)
        else $error("delay count not one per clock");

    property p_width_end;
        @(posedge ref_clk) disable iff (reset)
        (r.state == SPV_HIGH && r.cnt <= 24'h00_0001) |=>
            (!pulse && r.state == SPV_IDLE);
    endproperty
    a_width_end: assert property (p_width_end)
        else $error("pulse did not fall at width end");

    property p_long_tail;
        @(posedge ref_clk) disable iff (reset)
        (r.state == SPV_HOLD && sof && mode == `SPV_MODE_LONG) |=>
            (r.state == SPV_TAIL && pulse &&
            r.cnt == $past(width_ext));
    endproperty
    a_long_tail: assert property (p_long_tail)
        else $error("long pulse tail not started by frame start");

    property p_long_hold;
        @(posedge ref_clk) disable iff (reset)
        (r.state == SPV_HOLD && !sof && mode == `SPV_MODE_LONG) |=>
            (pulse && r.state == SPV_HOLD);
    endproperty
    a_long_hold: assert property (p_long_hold)
        else $error("long pulse dropped before frame start");

endmodule

// File: logic/spv_pad_ctrl.sv
// sensor pad control top: register file, pad source muxes and
// frame pulse output on the shared frame sync and general pads
// assumes: serial control bus slave outside presents byte accesses
// here as one-cycle strobes; pad wires are resolved outside from
// the active-low enables
`timescale 1ns/100ps
`include "spv_regs.svh"

// Behaviour
// - drive strength code 1x to 4x
// - general pad direction from bit 0
// - general pad source: datapath or register
// - forced general pad level from bit 4
// - general datapath picks frame or line sync
// - frame sync pad direction from bit 7
// - frame sync pad source and forced level
// - strobe pad direction from bit 3
// - strobe pad source and forced level
// - led pad direction from bit 5
// - led pad driven by debug or generator
// - three byte delay before pulse rise
// - two byte width sets pulse length
// - one count equals one clock
// - mode one triggers on frame start
// - mode two triggers on frame end
// - mode three long pulse, end then start
// - frame sync pad is input or output
// - general pad carries syncs or plain io
module spv_pad_ctrl (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic sof,
    input wire logic eof,
    input wire logic hsync,
    input wire logic strobe_src,
    input wire logic led_gen,
    input wire logic led_debug,
    input wire logic frame_sync_in_pad_in,
    output logic frame_sync_in_pad_out,
    output logic frame_sync_in_pad_oe_n,
    input wire logic strobe_pad_in,
    output logic strobe_pad_out,
    output logic strobe_pad_oe_n,
    input wire logic led_pad_in,
    output logic led_pad_out,
    output logic led_pad_oe_n,
    input wire logic general_pad_in,
    output logic general_pad_out,
    output logic general_pad_oe_n,
    output logic [1:0] pad_drive_code,
    output logic [3:0] pad_level,
    output logic frame_pulse
);
    import spv_pkg::*;

    spv_top_s r;
    spv_top_s next_r;
    logic [3:0] pad_raw;
    logic [3:0] pad_sync;
    logic gen_pulse;
    logic [23:0] delay_word;
    logic [15:0] width_word;
    logic gp_normal;
    logic [1:0] fs_pad;
    logic [1:0] st_pad;
    logic [1:0] gp_pad;
    logic [7:0] level_byte;

    // returns {out, oe_n}; an input pad drives low with enable off
    function automatic logic [1:0] pad_mux(
        input logic is_out,
        input logic use_reg,
        input logic reg_val,
        input logic normal
    );
        logic v;
        v = use_reg ? reg_val : normal;
        if (is_out) begin
            pad_mux = {v, 1'b0};
        end else begin
            pad_mux = {1'b0, 1'b1};
        end
    endfunction

    assign pad_raw = {general_pad_in, led_pad_in, strobe_pad_in,
        frame_sync_in_pad_in};

    spv_pad_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .d(pad_raw),
        .q(pad_sync)
    );

    assign delay_word = {r.delay_b2, r.delay_b1, r.delay_b0};
    assign width_word = {r.width_hi, r.width_lo};

    spv_frame_pulse u_pulse (
        .ref_clk(ref_clk),
        .reset(reset),
        .mode(r.mode[`SPV_MODE_MSB:`SPV_MODE_LSB]),
        .delay(delay_word),
        .width(width_word),
        .sof(sof),
        .eof(eof),
        .pulse(gen_pulse)
    );

    always_comb begin
        next_r = r;
        next_r.rvalid = 1'b0;
        level_byte = 8'h00;
        level_byte[`SPV_FS_VAL_BIT] = pad_sync[0];
        level_byte[`SPV_ST_VAL_BIT] = pad_sync[1];
        level_byte[`SPV_LED_DIR_BIT] = pad_sync[2];
        level_byte[`SPV_GP_VAL_BIT] = pad_sync[3];

        // write decode; unmapped and read-only addresses ignore data
        if (reg_we) begin
            if (reg_addr == `SPV_ADDR_DRIVE) begin
                next_r.drive = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_DIR_A) begin
                next_r.dir_a = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_FS_DIR) begin
                next_r.fs_dir = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_FORCE_A) begin
                next_r.force_a = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_GP_FORCE) begin
                next_r.gp_force = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_SEL_A) begin
                next_r.sel_a = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_GP_SEL) begin
                next_r.gp_sel = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_GP_CHOICE) begin
                next_r.gp_choice = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_LED_SEL) begin
                next_r.led_sel = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_MODE) begin
                next_r.mode = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_WIDTH_HI) begin
                next_r.width_hi = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_WIDTH_LO) begin
                next_r.width_lo = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_DELAY_B2) begin
                next_r.delay_b2 = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_DELAY_B1) begin
                next_r.delay_b1 = reg_wdata;
            end else if (reg_addr == `SPV_ADDR_DELAY_B0) begin
                next_r.delay_b0 = reg_wdata;
            end
        end

        // read decode; unmapped addresses answer zero
        if (reg_re) begin
            next_r.rvalid = 1'b1;
            if (reg_addr == `SPV_ADDR_DRIVE) begin
                next_r.rdata = r.drive;
            end else if (reg_addr == `SPV_ADDR_DIR_A) begin
                next_r.rdata = r.dir_a;
            end else if (reg_addr == `SPV_ADDR_FS_DIR) begin
                next_r.rdata = r.fs_dir;
            end else if (reg_addr == `SPV_ADDR_FORCE_A) begin
                next_r.rdata = r.force_a;
            end else if (reg_addr == `SPV_ADDR_GP_FORCE) begin
                next_r.rdata = r.gp_force;
            end else if (reg_addr == `SPV_ADDR_PAD_LEVEL) begin
                next_r.rdata = level_byte;
            end else if (reg_addr == `SPV_ADDR_SEL_A) begin
                next_r.rdata = r.sel_a;
            end else if (reg_addr == `SPV_ADDR_GP_SEL) begin
                next_r.rdata = r.gp_sel;
            end else if (reg_addr == `SPV_ADDR_GP_CHOICE) begin
                next_r.rdata = r.gp_choice;
            end else if (reg_addr == `SPV_ADDR_LED_SEL) begin
                next_r.rdata = r.led_sel;
            end else if (reg_addr == `SPV_ADDR_MODE) begin
                next_r.rdata = r.mode;
            end else if (reg_addr == `SPV_ADDR_WIDTH_HI) begin
                next_r.rdata = r.width_hi;
            end else if (reg_addr == `SPV_ADDR_WIDTH_LO) begin
                next_r.rdata = r.width_lo;
            end else if (reg_addr == `SPV_ADDR_DELAY_B2) begin
                next_r.rdata = r.delay_b2;
            end else if (reg_addr == `SPV_ADDR_DELAY_B1) begin
                next_r.rdata = r.delay_b1;
            end else if (reg_addr == `SPV_ADDR_DELAY_B0) begin
                next_r.rdata = r.delay_b0;
            end else begin
                next_r.rdata = 8'h00;
            end
        end

        // pads follow the registers one clock later, so every pad
        // pin comes from a flop and never glitches on a mux change
        next_r.drive_code = r.drive[`SPV_DRIVE_MSB:`SPV_DRIVE_LSB];

        fs_pad = pad_mux(r.fs_dir[`SPV_FS_DIR_BIT],
            r.sel_a[`SPV_FS_SEL_BIT],
            r.force_a[`SPV_FS_VAL_BIT], gen_pulse);
        next_r.fs_out = fs_pad[1];
        next_r.fs_oe_n = fs_pad[0];

        st_pad = pad_mux(r.dir_a[`SPV_ST_DIR_BIT],
            r.sel_a[`SPV_ST_SEL_BIT],
            r.force_a[`SPV_ST_VAL_BIT], strobe_src);
        next_r.st_out = st_pad[1];
        next_r.st_oe_n = st_pad[0];

        gp_normal = r.gp_choice[`SPV_GP_CHOICE_BIT] ?
            hsync : gen_pulse;
        gp_pad = pad_mux(r.dir_a[`SPV_GP_DIR_BIT],
            r.gp_sel[`SPV_GP_SEL_BIT],
            r.gp_force[`SPV_GP_VAL_BIT], gp_normal);
        next_r.gp_out = gp_pad[1];
        next_r.gp_oe_n = gp_pad[0];

        // the led pad has no forced level; its select picks the source
        if (r.sel_a[`SPV_LED_DIR_BIT]) begin
            next_r.led_out = r.led_sel[`SPV_LED_SEL_BIT] ?
                led_gen : led_debug;
            next_r.led_oe_n = 1'b0;
        end else begin
            next_r.led_out = 1'b0;
            next_r.led_oe_n = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r <= '0;
            r.mode <= `SPV_RST_MODE;
            r.fs_oe_n <= 1'b1;
            r.st_oe_n <= 1'b1;
            r.led_oe_n <= 1'b1;
            r.gp_oe_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign reg_rvalid = r.rvalid;
    assign pad_drive_code = r.drive_code;
    assign frame_sync_in_pad_out = r.fs_out;
    assign frame_sync_in_pad_oe_n = r.fs_oe_n;
    assign strobe_pad_out = r.st_out;
    assign strobe_pad_oe_n = r.st_oe_n;
    assign led_pad_out = r.led_out;
    assign led_pad_oe_n = r.led_oe_n;
    assign general_pad_out = r.gp_out;
    assign general_pad_oe_n = r.gp_oe_n;
    assign pad_level = pad_sync;
    assign frame_pulse = gen_pulse;

    property p_drive;
        @(posedge ref_clk) disable iff (reset)
        (reg_we && reg_addr == `SPV_ADDR_DRIVE) |=> ##1
            pad_drive_code == $past(reg_wdata[1:0], 2);
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive code does not follow its register");

    property p_gp_input;
        @(posedge ref_clk) disable iff (reset)
        !r.dir_a[`SPV_GP_DIR_BIT] |=>
            (general_pad_oe_n && !general_pad_out);
    endproperty
    a_gp_input: assert property (p_gp_input)
        else $error("general pad driven while input");

    property p_gp_forced;
        @(posedge ref_clk) disable iff (reset)
        (r.dir_a[`SPV_GP_DIR_BIT] && r.gp_sel[`SPV_GP_SEL_BIT]) |=>
            (!general_pad_oe_n &&
            general_pad_out == $past(r.gp_force[`SPV_GP_VAL_BIT]));
    endproperty
    a_gp_forced: assert property (p_gp_forced)
        else $error("general pad not at forced level");

    property p_gp_line;
        @(posedge ref_clk) disable iff (reset)
        (r.dir_a[`SPV_GP_DIR_BIT] && !r.gp_sel[`SPV_GP_SEL_BIT] &&
            r.gp_choice[`SPV_GP_CHOICE_BIT]) |=>
            general_pad_out == $past(hsync);
    endproperty
    a_gp_line: assert property (p_gp_line)
        else $error("general pad not carrying line sync");

    property p_fs_pulse;
        @(posedge ref_clk) disable iff (reset)
        (r.fs_dir[`SPV_FS_DIR_BIT] && !r.sel_a[`SPV_FS_SEL_BIT]) |=>
            (!frame_sync_in_pad_oe_n &&
            frame_sync_in_pad_out == $past(gen_pulse));
    endproperty
    a_fs_pulse: assert property (p_fs_pulse)
        else $error("frame sync pad not carrying frame pulse");

    property p_fs_input;
        @(posedge ref_clk) disable iff (reset)
        !r.fs_dir[`SPV_FS_DIR_BIT] |=> frame_sync_in_pad_oe_n;
    endproperty
    a_fs_input: assert property (p_fs_input)
        else $error("frame sync pad driven while input");

    property p_strobe;
        @(posedge ref_clk) disable iff (reset)
        (r.dir_a[`SPV_ST_DIR_BIT] && r.sel_a[`SPV_ST_SEL_BIT]) |=>
            (!strobe_pad_oe_n &&
            strobe_pad_out == $past(r.force_a[`SPV_ST_VAL_BIT]));
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("strobe pad not at forced level");

    property p_led;
        @(posedge ref_clk) disable iff (reset)
        (r.sel_a[`SPV_LED_DIR_BIT] && r.led_sel[`SPV_LED_SEL_BIT]) |=>
            (!led_pad_oe_n && led_pad_out == $past(led_gen));
    endproperty
    a_led: assert property (p_led)
        else $error("led pad not following generator");

endmodule

// File: verif/spv_host_model.sv
// host side of the four pads: drives its own level onto a pad only
// while the block leaves that pad as an input
// assumes: one bit per pad, b0 frame sync, b1 strobe, b2 led, b3 general
`timescale 1ns/100ps
module spv_host_model (
    input wire logic [3:0] lvl,
    input wire logic [3:0] pout,
    input wire logic [3:0] poe_n,
    output logic [3:0] pin
);
    // host lets go of a pad the block drives, so no contention
    assign pin = (poe_n & lvl) | (~poe_n & pout);
endmodule

// File: verif/tb_spv_pad_ctrl.sv
// testbench for the pad control block: registers, pad muxes, pulses
// assumes: host model resolves every pad wire
`timescale 1ns/100ps
`include "spv_regs.svh"
module tb_spv_pad_ctrl;
    logic ref_clk = 0, reset = 1, reg_we = 0, reg_re = 0;
    logic sof = 0, eof = 0, hsync = 0, strobe_src = 0;
    logic led_gen = 0, led_debug = 0, reg_rvalid, frame_pulse;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [1:0] pad_drive_code;
    logic [3:0] host_lvl = 4'h0, pin, pout, poe_n, pad_level;
    int err_count = 0, samples_checked = 0, rise, fall, prise, i;
    always #20 ref_clk = ~ref_clk;
    spv_host_model host (.lvl(host_lvl), .pout(pout), .poe_n(poe_n),
        .pin(pin));
    spv_pad_ctrl dut (.ref_clk(ref_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sof(sof), .eof(eof), .hsync(hsync), .strobe_src(strobe_src),
        .led_gen(led_gen), .led_debug(led_debug),
        .frame_sync_in_pad_in(pin[0]), .frame_sync_in_pad_out(pout[0]),
        .frame_sync_in_pad_oe_n(poe_n[0]), .strobe_pad_in(pin[1]),
        .strobe_pad_out(pout[1]), .strobe_pad_oe_n(poe_n[1]),
        .led_pad_in(pin[2]), .led_pad_out(pout[2]),
        .led_pad_oe_n(poe_n[2]), .general_pad_in(pin[3]),
        .general_pad_out(pout[3]), .general_pad_oe_n(poe_n[3]),
        .pad_drive_code(pad_drive_code), .pad_level(pad_level),
        .frame_pulse(frame_pulse));
    task tick;
        @(posedge ref_clk);
        #1;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp, string m);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task chkn(input int got, input int exp, input string m);
        samples_checked++;
        if (got != exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task give_verdict;
        $display("compares %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // write strobe dropped for a cycle so back-to-back calls stay clean
    task wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1;
        tick;
        reg_we = 0;
        tick;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] exp, input string m);
        reg_addr = a;
        reg_re = 1;
        tick;
        reg_re = 0;
        // the valid flag stands for one cycle only, so look at it now
        chk({7'h00, reg_rvalid}, 8'h01, m);
        chk(reg_rdata, exp, m);
        tick;
    endtask
    // trigger at edge 0, optional sof at edge s, record pulse edges
    task pulse(input logic use_eof, input int s);
        int k;
        rise = 0;
        fall = 0;
        prise = 0;
        sof = !use_eof;
        eof = use_eof;
        for (k = 0; k < 1000 && fall == 0; k++) begin
            tick;
            sof = (k + 1 == s);
            eof = 0;
            // after k + 1 ticks the bench stands in cycle k + 1
            if (frame_pulse === 1 && rise == 0) rise = k + 1;
            if (pout[3] === 1 && prise == 0) prise = k + 1;
            if (frame_pulse === 0 && rise != 0) fall = k + 1;
        end
        if (fall == 0) begin
            chkn(0, 1, "pulse never ended");
            give_verdict;
        end
    endtask
    // one sof the mode must ignore; a wrong start would be high here
    task quiet(input string m);
        sof = 1;
        tick;
        sof = 0;
        repeat (6) tick;
        chk({7'h00, frame_pulse}, 8'h00, m);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        reset = 0;
        tick;
        rd(`SPV_ADDR_DRIVE, 8'h00, "drive reset");
        rd(`SPV_ADDR_MODE, 8'h01, "mode reset");
        chk({4'h0, poe_n}, 8'h0f, "pads released");
        for (i = 0; i < 4; i++) begin
            wr(`SPV_ADDR_DRIVE, {6'h3f, i[1:0]});
            tick;
            chk({6'h00, pad_drive_code}, {6'h00, i[1:0]}, "drive");
        end
        rd(`SPV_ADDR_DRIVE, 8'hff, "drive byte");
        host_lvl = 4'ha;
        repeat (3) tick;
        chk({4'h0, pad_level}, 8'h0a, "pad levels");
        wr(`SPV_ADDR_PAD_LEVEL, 8'hff);
        rd(`SPV_ADDR_PAD_LEVEL, 8'h14, "level status");
        rd(16'h5000, 8'h00, "unmapped");
        $display("test registers done");
        wr(`SPV_ADDR_DIR_A, 8'h09);
        wr(`SPV_ADDR_GP_SEL, 8'h10);
        wr(`SPV_ADDR_GP_FORCE, 8'h10);
        tick;
        chk({pout[3], poe_n[3]}, 8'h02, "gp forced high");
        wr(`SPV_ADDR_GP_FORCE, 8'h00);
        tick;
        chk(pout[3], 8'h00, "gp forced low");
        wr(`SPV_ADDR_GP_SEL, 8'h00);
        wr(`SPV_ADDR_GP_CHOICE, 8'h10);
        hsync = 1;
        repeat (2) tick;
        chk(pout[3], 8'h01, "gp line sync");
        wr(`SPV_ADDR_SEL_A, 8'h84);
        wr(`SPV_ADDR_FORCE_A, 8'h84);
        wr(`SPV_ADDR_FS_DIR, 8'h80);
        tick;
        chk({pout[1:0], poe_n[1:0]}, 8'h0c, "fs strobe forced");
        strobe_src = 1;
        led_gen = 1;
        wr(`SPV_ADDR_SEL_A, 8'h20);
        wr(`SPV_ADDR_LED_SEL, 8'h80);
        tick;
        chk({pout[2:0], poe_n[2]}, 8'h0c, "strobe led path");
        wr(`SPV_ADDR_LED_SEL, 8'h00);
        tick;
        chk(pout[2], 8'h00, "led debug");
        $display("test pads done");
        wr(`SPV_ADDR_GP_CHOICE, 8'h00);
        wr(`SPV_ADDR_DELAY_B0, 8'h03);
        wr(`SPV_ADDR_WIDTH_LO, 8'h02);
        pulse(0, 0);
        chkn(rise, 5, "sof rise");
        chkn(fall - rise, 2, "sof width");
        chkn(prise, rise + 1, "gp carries pulse");
        wr(`SPV_ADDR_MODE, 8'h02);
        wr(`SPV_ADDR_DELAY_B1, 8'h01);
        wr(`SPV_ADDR_DELAY_B0, 8'h00);
        wr(`SPV_ADDR_WIDTH_HI, 8'h01);
        wr(`SPV_ADDR_WIDTH_LO, 8'h00);
        pulse(1, 0);
        chkn(rise, 258, "eof rise");
        chkn(fall - rise, 256, "eof width");
        wr(`SPV_ADDR_DELAY_B1, 8'h00);
        wr(`SPV_ADDR_DELAY_B0, 8'h03);
        wr(`SPV_ADDR_WIDTH_HI, 8'h00);
        wr(`SPV_ADDR_WIDTH_LO, 8'h04);
        quiet("end mode took sof");
        wr(`SPV_ADDR_MODE, 8'h03);
        pulse(1, 20);
        chkn(rise, 5, "long rise");
        chkn(fall, 25, "long fall");
        wr(`SPV_ADDR_MODE, 8'h00);
        quiet("off mode took sof");
        $display("test pulses done");
        give_verdict;
    end
endmodule
